// ===== hdl/cfg_port_pkg.sv
package cfg_port_pkg;

  // register space
  localparam int ADDR_W = 7;
  localparam int IDX_W = 5;
  localparam int REG_COUNT = 23;
  localparam logic [ADDR_W-1:0] LAST_ADDR = 7'h16;
  localparam logic [ADDR_W-1:0] ADDR_MAX = 7'h7f;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;

  // divider register offsets
  localparam logic [IDX_W-1:0] OFS_FSK0_SWALLOW = 5'h0a;
  localparam logic [IDX_W-1:0] OFS_FSK0_MAIN_HI = 5'h0b;
  localparam logic [IDX_W-1:0] OFS_FSK0_MAIN_LO = 5'h0c;
  localparam logic [IDX_W-1:0] OFS_FSK0_REF_HI = 5'h0d;
  localparam logic [IDX_W-1:0] OFS_FSK0_REF_LO = 5'h0e;
  localparam logic [IDX_W-1:0] OFS_FSK1_SWALLOW = 5'h0f;
  localparam logic [IDX_W-1:0] OFS_FSK1_MAIN_HI = 5'h10;
  localparam logic [IDX_W-1:0] OFS_FSK1_MAIN_LO = 5'h11;
  localparam logic [IDX_W-1:0] OFS_FSK1_REF_HI = 5'h12;
  localparam logic [IDX_W-1:0] OFS_FSK1_REF_LO = 5'h13;

  // field widths
  localparam int SWALLOW_W = 6;
  localparam int DIV_W = 12;
  localparam int DIV_HI_W = 4;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_ADDR,
    PH_WDATA,
    PH_RDATA
  } phase_e;

  typedef struct packed {
    logic [SWALLOW_W-1:0] swallow;
    logic [DIV_W-1:0] main_div;
    logic [DIV_W-1:0] ref_div;
  } div_set_s;

  typedef struct packed {
    logic cs;
    logic sclk;
    logic io;
  } pins_s;

  typedef logic [REG_COUNT-1:0][7:0] reg_file_t;

  typedef struct packed {
    phase_e phase;
    pins_s pins_q;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic [ADDR_W-1:0] addr;
    reg_file_t stage;
    logic [REG_COUNT-1:0] dirty;
    reg_file_t active;
    logic io_out;
    logic io_oe;
    logic load;
    div_set_s div_sel;
  } port_state_s;

endpackage

// ===== hdl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // two stages before any logic looks at a pin
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= '0;
      q <= '0;
    end else if (clk_en) begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

`default_nettype wire

// ===== hdl/three_wire_config_port.sv
// Contract
// - first octet: 7-bit address msb first, direction
// - direction one reads, zero writes
// - every register transfer is eight bits msb first
// - write octets land at rising addresses
// - write bits sampled on falling serial clock
// - select fall after write makes load pulse
// - read data driven, updated on rising edges
// - reads start 0 to 22, address advances
// - reading never changes register contents
// - main/reference dividers 12 bits, swallow 6
// - set zero for symbol 0, set one for 1
// - receive uses divider set zero only
// - data line never driven during writes
`timescale 1ns/1ps
`default_nettype none

module three_wire_config_port
  import cfg_port_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic cs_pin,
  input wire logic sclk_pin,
  input wire logic io_in,
  output logic io_out,
  output logic io_oe,
  input wire logic tx_symbol,
  input wire logic rx_mode,
  output logic load_pulse,
  output reg_file_t cfg_regs,
  output div_set_s div_active
);

  port_state_s st_r;
  port_state_s st_nxt;
  pins_s pins_raw;
  pins_s pins_s_q;

  logic cs_rise;
  logic cs_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic [7:0] rd_byte;
  logic [7:0] wr_byte;
  logic [ADDR_W-1:0] addr_inc;
  div_set_s set0;
  div_set_s set1;

  // serial pins come from the host's clock, not ours
  assign pins_raw = {cs_pin, sclk_pin, io_in};

  pin_sync #(
    .W(3)
  ) u_pin_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .d(pins_raw),
    .q(pins_s_q)
  );

  // edges of the synchronised pins
  assign cs_rise = pins_s_q.cs & ~st_r.pins_q.cs;
  assign cs_fall = ~pins_s_q.cs & st_r.pins_q.cs;
  assign sclk_rise = pins_s_q.sclk & ~st_r.pins_q.sclk;
  assign sclk_fall = ~pins_s_q.sclk & st_r.pins_q.sclk;

  // octet completed by the bit being sampled now
  assign wr_byte = {st_r.shift[6:0], pins_s_q.io};

  // address counter saturates past the top of the space
  assign addr_inc = (st_r.addr == ADDR_MAX) ? ADDR_MAX : st_r.addr + 7'h01;

  // read source is the active set; unmapped reads as zero
  always_comb begin
    if (st_r.addr <= LAST_ADDR) begin
      rd_byte = st_r.active[st_r.addr[IDX_W-1:0]];
    end else begin
      rd_byte = 8'h00;
    end
  end

  // divider sets assembled from the active registers
  always_comb begin
    set0.swallow = st_r.active[OFS_FSK0_SWALLOW][SWALLOW_W-1:0];
    set0.main_div = {st_r.active[OFS_FSK0_MAIN_HI][DIV_HI_W-1:0],
                     st_r.active[OFS_FSK0_MAIN_LO]};
    set0.ref_div = {st_r.active[OFS_FSK0_REF_HI][DIV_HI_W-1:0],
                    st_r.active[OFS_FSK0_REF_LO]};
    set1.swallow = st_r.active[OFS_FSK1_SWALLOW][SWALLOW_W-1:0];
    set1.main_div = {st_r.active[OFS_FSK1_MAIN_HI][DIV_HI_W-1:0],
                     st_r.active[OFS_FSK1_MAIN_LO]};
    set1.ref_div = {st_r.active[OFS_FSK1_REF_HI][DIV_HI_W-1:0],
                    st_r.active[OFS_FSK1_REF_LO]};
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.pins_q = pins_s_q;
    st_nxt.load = 1'b0;

    // set zero in receive or for a 0 symbol, set one otherwise
    if (rx_mode) begin
      st_nxt.div_sel = set0;
    end else if (tx_symbol) begin
      st_nxt.div_sel = set1;
    end else begin
      st_nxt.div_sel = set0;
    end

    if (cs_rise) begin
      // fresh transaction: bit count and shift cleared, line released
      st_nxt.phase = PH_ADDR;
      st_nxt.bit_cnt = BIT_FIRST;
      st_nxt.shift = 8'h00;
      st_nxt.io_oe = 1'b0;
      st_nxt.io_out = 1'b0;
    end else if (cs_fall) begin
      // partial octet is dropped, line handed back
      if (st_r.phase == PH_WDATA && st_r.dirty != '0) begin
        st_nxt.load = 1'b1;
        for (int i = 0; i < REG_COUNT; i++) begin
          if (st_r.dirty[i]) begin
            st_nxt.active[i] = st_r.stage[i];
          end
        end
      end
      st_nxt.dirty = '0;
      st_nxt.phase = PH_IDLE;
      st_nxt.bit_cnt = BIT_FIRST;
      st_nxt.io_oe = 1'b0;
      st_nxt.io_out = 1'b0;
    end else if (pins_s_q.cs) begin
      case (st_r.phase)
        PH_ADDR: begin
          if (sclk_fall) begin
            st_nxt.shift = wr_byte;
            st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
            if (st_r.bit_cnt == BIT_LAST) begin
              st_nxt.addr = st_r.shift[ADDR_W-1:0];
              st_nxt.bit_cnt = BIT_FIRST;
              if (pins_s_q.io) begin
                st_nxt.phase = PH_RDATA;
              end else begin
                st_nxt.phase = PH_WDATA;
              end
            end
          end
        end
        PH_WDATA: begin
          st_nxt.io_oe = 1'b0;
          if (sclk_fall) begin
            st_nxt.shift = wr_byte;
            st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
            if (st_r.bit_cnt == BIT_LAST) begin
              if (st_r.addr <= LAST_ADDR) begin
                st_nxt.stage[st_r.addr[IDX_W-1:0]] = wr_byte;
                st_nxt.dirty[st_r.addr[IDX_W-1:0]] = 1'b1;
              end
              st_nxt.addr = addr_inc;
              st_nxt.bit_cnt = BIT_FIRST;
            end
          end
        end
        PH_RDATA: begin
          if (sclk_rise) begin
            st_nxt.io_oe = 1'b1;
            st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
            if (st_r.bit_cnt == BIT_FIRST) begin
              st_nxt.io_out = rd_byte[7];
              st_nxt.shift = {rd_byte[6:0], 1'b0};
              st_nxt.addr = addr_inc;
            end else begin
              st_nxt.io_out = st_r.shift[7];
              st_nxt.shift = {st_r.shift[6:0], 1'b0};
            end
          end
        end
        default: begin
          st_nxt.phase = PH_IDLE;
          st_nxt.io_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r.phase <= PH_IDLE;
      st_r.pins_q <= '0;
      st_r.bit_cnt <= BIT_FIRST;
      st_r.shift <= 8'h00;
      st_r.addr <= '0;
      st_r.stage <= {REG_COUNT{REG_RESET}};
      st_r.dirty <= '0;
      st_r.active <= {REG_COUNT{REG_RESET}};
      st_r.io_out <= 1'b0;
      st_r.io_oe <= 1'b0;
      st_r.load <= 1'b0;
      st_r.div_sel <= '0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign io_out = st_r.io_out;
  assign io_oe = st_r.io_oe;
  assign load_pulse = st_r.load;
  assign cfg_regs = st_r.active;
  assign div_active = st_r.div_sel;

endmodule

`default_nettype wire

// ===== testbench/cfg_host.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_host (
  input wire logic core_clk,
  input wire logic io_out,
  input wire logic io_oe,
  output logic cs,
  output logic sclk,
  output logic io
);
  logic drv = 1'b1;
  logic val = 1'b0;
  logic [7:0] wq[$];
  logic [7:0] rq[$];
  initial begin
    cs = 1'b0;
    sclk = 1'b0;
  end
  // floating line shows the inverse of the last host bit
  assign io = drv ? val : (io_oe ? io_out : ~val);
  task octet(input logic [7:0] w, input int nb, output logic [7:0] r);
    for (int i = 7; i > 7 - nb; i--) begin
      @(posedge core_clk);
      sclk <= 1'b1;
      val <= w[i];
      repeat (4) @(posedge core_clk);
      sclk <= 1'b0;
      #1 r[i] = io;
      repeat (3) @(posedge core_clk);
    end
  endtask
  task xfer(input logic [6:0] a, input logic rd, input int n, input logic part);
    logic [7:0] r;
    @(posedge core_clk);
    cs <= 1'b1;
    repeat (4) @(posedge core_clk);
    octet({a, rd}, 8, r);
    drv <= !rd;
    rq = {};
    for (int k = 0; k < n; k++) begin
      octet(rd ? 8'h00 : wq[k], 8, r);
      rq.push_back(r);
    end
    if (part) octet(8'hff, 3, r);
    @(posedge core_clk);
    cs <= 1'b0;
    repeat (6) @(posedge core_clk);
    drv <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== testbench/cfg_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_port_monitor
  import cfg_port_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic cs_pin,
  input wire logic sclk_pin,
  input wire logic tx_symbol,
  input wire logic rx_mode,
  input wire logic io_out,
  input wire logic io_oe,
  input wire logic load_pulse,
  input wire reg_file_t cfg_regs,
  input wire div_set_s div_active
);
  logic [IDX_W-1:0] b;
  div_set_s want;
  assign b = (tx_symbol && !rx_mode) ? OFS_FSK1_SWALLOW : OFS_FSK0_SWALLOW;
  assign want = {cfg_regs[b][5:0], cfg_regs[b+1][3:0], cfg_regs[b+2], cfg_regs[b+3][3:0],
    cfg_regs[b+4]};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence cs_idle; !cs_pin [*6]; endsequence
  sequence sclk_rose; $past(sclk_pin, 3) && !$past(sclk_pin, 6); endsequence
  a_load_single: assert property (load_pulse |=> !load_pulse)
    else $error("load too long");
  a_load_cs_low: assert property (load_pulse |-> !cs_pin && !$past(cs_pin, 2))
    else $error("load while selected");
  a_regs_on_load: assert property ($changed(cfg_regs) |-> load_pulse)
    else $error("regs moved");
  a_oe_needs_cs: assert property (io_oe |-> $past(cs_pin, 4))
    else $error("oe unselected");
  a_oe_idle_off: assert property (cs_idle |-> !io_oe)
    else $error("oe stuck");
  a_oe_on_rise: assert property ($rose(io_oe) |-> sclk_rose)
    else $error("oe off edge");
  a_out_on_rise: assert property ($changed(io_out) && io_oe && $past(io_oe) |-> sclk_rose)
    else $error("out off edge");
  a_div_select: assert property ($past(clk_en) |-> div_active == $past(want))
    else $error("wrong set");
endmodule
bind three_wire_config_port cfg_port_monitor u_mon (.core_clk, .reset_n, .clk_en, .cs_pin, .sclk_pin,
  .tx_symbol, .rx_mode, .io_out, .io_oe, .load_pulse, .cfg_regs, .div_active);
`default_nettype wire

// ===== testbench/three_wire_config_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module three_wire_config_port_tb;
  import cfg_port_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic tx_symbol = 1'b0;
  logic rx_mode = 1'b0;
  logic clk_en = 1'b1;
  logic cs_pin, sclk_pin, io, io_out, io_oe, load_pulse;
  reg_file_t cfg_regs;
  reg_file_t model = '0;
  div_set_s div_active;
  logic [31:0] seed = 32'h3091;
  int fails = 0;
  int tests_run = 0;
  int loads = 0;
  int cycles = 0;
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // host keeps swallow at one and main divider above it
  function logic [7:0] host_val(input int adr, input logic [7:0] v);
    if (adr == OFS_FSK0_SWALLOW || adr == OFS_FSK1_SWALLOW) return 8'h01;
    if (adr == OFS_FSK0_MAIN_LO || adr == OFS_FSK1_MAIN_LO) return v | 8'h02;
    return v;
  endfunction
  function div_set_s expd(input logic s);
    logic [4:0] b;
    b = s ? OFS_FSK1_SWALLOW : OFS_FSK0_SWALLOW;
    return {model[b][5:0], model[b+1][3:0], model[b+2], model[b+3][3:0], model[b+4]};
  endfunction
  task chk(input logic [183:0] got, input logic [183:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task test_done();
    if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always #2 core_clk = ~core_clk;
  cfg_host u_host (.core_clk, .io_out, .io_oe, .cs(cs_pin), .sclk(sclk_pin), .io);
  three_wire_config_port u_dut (.core_clk, .reset_n, .clk_en, .cs_pin, .sclk_pin,
    .io_in(io), .io_out, .io_oe, .tx_symbol, .rx_mode, .load_pulse, .cfg_regs, .div_active);
  always @(posedge core_clk) begin
    seed <= lfsr(seed);
    tx_symbol <= seed[3];
    rx_mode <= seed[7] & seed[9];
    cycles <= cycles + 1;
    if (load_pulse) loads <= loads + 1;
    if (u_host.drv && io_oe) chk(1, 0);
    if (cycles == 40000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    int a;
    int n;
    logic s;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(cfg_regs, {REG_COUNT{REG_RESET}});
    // full load first, then random spans, odd rounds end on a broken octet
    for (int t = 0; t < 4; t++) begin
      a = t ? seed[4:0] % 23 : 0;
      n = t ? seed[12:8] % (23 - a) + 1 : 23;
      u_host.wq = {};
      for (int k = 0; k < n; k++) begin
        @(posedge core_clk);
        u_host.wq.push_back(host_val(a + k, seed[7:0]));
        model[a+k] = host_val(a + k, seed[7:0]);
      end
      u_host.xfer(a[6:0], 1'b0, n, t[0]);
      u_host.xfer(a[6:0], 1'b1, n, 1'b0);
      for (int k = 0; k < n; k++) chk(u_host.rq[k], model[a+k]);
      chk(cfg_regs, model);
      chk(loads, t + 1);
    end
    // write runs past the last register, read beyond it
    u_host.wq = '{8'h5a, 8'ha5};
    model[22] = 8'h5a;
    u_host.xfer(LAST_ADDR, 1'b0, 2, 1'b0);
    u_host.xfer(LAST_ADDR + 7'h1, 1'b1, 1, 1'b0);
    chk(u_host.rq[0], 8'h00);
    chk(cfg_regs, model);
    #1;
    repeat (64) begin
      s = tx_symbol && !rx_mode;
      @(posedge core_clk);
      #1 chk(div_active, expd(s));
    end
    // a write while the clock enable is low must leave no trace
    @(posedge core_clk);
    clk_en <= 1'b0;
    u_host.wq = '{~model[3]};
    u_host.xfer(7'h03, 1'b0, 1, 1'b0);
    clk_en <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(cfg_regs, model);
    chk(loads, 5);
    test_done();
  end
endmodule
`default_nettype wire
